// *** design/ctic_top.sv ***
// Purpose: cpu throttle and idle control register with sleep/idle sequencing
// Assumes: sleep, irq and return strobes are one-clock pulses from core logic
// Notes: AHB-Lite slave, zero wait states, always OKAY
// Functional notes
// - idle select: sleep stops only cpu clock
// - idle clear: sleep stops cpu and system
// - throttle enable gates cpu cycle rate
// - recover bit clears throttle on irq entry
// - return-on bit sets throttle on return
// - ratio code 111 is 1:256 down to 1:2 at code 000
// - debug forces full speed, bit kept
// - idle kept over warm reset; others cleared
// - enabled irq wakes idle, select unchanged
// - watchdog wakes idle, throttle untouched
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ctic_map.svh"
module ctic_top (
    // clock and resets
    input wire logic clock,
    input wire logic sys_rst, // any reset
    input wire logic por_bor_rst, // power-on or brown-out, sync level
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // core events
    input wire logic periph_cyc, // peripheral instruction cycle strobe
    input wire logic sleep_exec, // sleep instruction executed
    input wire logic irq_entry, // isr entry
    input wire logic return_from_interrupt, // return instruction executed
    input wire logic irq_pending, // enabled interrupt pending, any global_irq_enable
    input wire logic watchdog_timer_timeout, // watchdog time-out
    input wire logic in_circuit_debug, // debug active
    // clock controls
    output logic cpu_cyc_en, // cpu may run this cycle
    output logic cpu_clk_en, // cpu clock running
    output logic sys_clk_en, // system clocks running
    output logic watchdog_timer_rst_req, // watchdog time-out not blocked
    output logic watchdog_timer_wake // watchdog woke device
);
    import ctic_pkg::*;
    typedef struct packed {
        logic idle_select;
        logic cpu_throttle_en;
        logic recover_on_irq;
        logic throttle_on_return;
        logic [2:0] ratio;
        ctic_pwr_t pwr;
        logic wr_pend; // write data phase pending
        logic rd_pend; // read data phase pending
        logic [11:0] addr; // latched address
        logic [31:0] rdata;
        logic cpu_cyc;
        logic wdt_rst;
        logic wdt_wake;
    } ctic_st_t;
    ctic_st_t s_q, s_d;
    ctic_gate_if gif ();
    logic dbg_s1, dbg_s2; // debug synchroniser
    logic wdt_s1, wdt_s2; // watchdog timeout synchroniser
    logic irq_s1, irq_s2; // pending irq synchroniser
    logic addr_ok; // valid address phase
    ctic_byte_t ctrl_rd; // control image
    logic idle_keep_q; // idle select kept over warm reset
    logic first_q; // reset active or first cycle after release
    // throttle gate
    ctic_gate u_gate (
        .clock(clock),
        .sys_rst(sys_rst),
        .gif(gif.gate)
    );
    // gate inputs; debug overrides enable only
    assign gif.run = s_q.cpu_throttle_en && !dbg_s2;
    assign gif.ratio = s_q.ratio;
    assign gif.cyc = periph_cyc;
    // pin synchronisers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dbg_s1 <= 1'b0;
            dbg_s2 <= 1'b0;
            wdt_s1 <= 1'b0;
            wdt_s2 <= 1'b0;
            irq_s1 <= 1'b0;
            irq_s2 <= 1'b0;
        end else begin
            dbg_s1 <= in_circuit_debug;
            dbg_s2 <= dbg_s1;
            wdt_s1 <= watchdog_timer_timeout;
            wdt_s2 <= wdt_s1;
            irq_s1 <= irq_pending;
            irq_s2 <= irq_s1;
        end
    end
    // address phase qualification
    assign addr_ok = hsel && hready && htrans[1];
    // readable image of control register, bit 3 reads zero
    always_comb begin
        ctrl_rd = {s_q.idle_select, s_q.cpu_throttle_en, s_q.recover_on_irq,
                   s_q.throttle_on_return, 1'b0, s_q.ratio};
    end
    // next state
    always_comb begin
        s_d = s_q;
        s_d.wdt_wake = 1'b0;
        s_d.wdt_rst = 1'b0;
        s_d.wr_pend = 1'b0;
        s_d.rd_pend = 1'b0;
        // restore idle select from keeper while reset and on release
        if (first_q) begin
            s_d.idle_select = idle_keep_q;
        end
        // bus address phase
        if (addr_ok) begin
            s_d.addr = haddr;
            s_d.wr_pend = hwrite;
            s_d.rd_pend = !hwrite;
        end
        // bus write data phase
        if (s_q.wr_pend && s_q.addr == `CTIC_CTRL_OFS) begin
            s_d.idle_select = hwdata[`CTIC_IDLE_BIT];
            s_d.cpu_throttle_en = hwdata[`CTIC_THR_BIT];
            s_d.recover_on_irq = hwdata[`CTIC_ROI_BIT];
            s_d.throttle_on_return = hwdata[`CTIC_TOR_BIT];
            s_d.ratio = hwdata[`CTIC_RATIO_HI:`CTIC_RATIO_LO];
        end
        // hardware set/clear after software write, so hardware wins
        if (irq_entry && s_q.recover_on_irq) begin
            s_d.cpu_throttle_en = 1'b0;
        end
        if (return_from_interrupt && s_q.throttle_on_return) begin
            s_d.cpu_throttle_en = 1'b1;
        end
        // read data for next phase
        s_d.rdata = 32'h0000_0000;
        if (addr_ok && !hwrite && haddr == `CTIC_CTRL_OFS) begin
            s_d.rdata = {24'h00_0000, ctrl_rd};
        end else if (addr_ok && !hwrite && haddr == `CTIC_STAT_OFS) begin
            s_d.rdata = {29'h0000_0000, dbg_s2, s_q.pwr};
        end
        // power sequencing
        case (s_q.pwr)
            CTIC_RUN: begin
                if (sleep_exec && !irq_s2) begin
                    s_d.pwr = s_q.idle_select ? CTIC_IDLE : CTIC_SLEEP;
                end
                s_d.wdt_rst = wdt_s2;
            end
            CTIC_IDLE: begin
                if (irq_s2) begin
                    s_d.pwr = CTIC_RUN;
                end else if (wdt_s2) begin
                    s_d.pwr = CTIC_RUN;
                    s_d.wdt_wake = 1'b1;
                end
            end
            CTIC_SLEEP: begin
                if (irq_s2 || wdt_s2) begin
                    s_d.pwr = CTIC_RUN;
                    s_d.wdt_wake = wdt_s2 && !irq_s2;
                end
            end
            default: begin
                s_d.pwr = CTIC_RUN;
            end
        endcase
        s_d.cpu_cyc = gif.pass && s_q.pwr == CTIC_RUN;
    end
    // state register; idle select survives warm reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    // separate flop for idle select so warm reset keeps it
    always_ff @(posedge clock or posedge por_bor_rst) begin
        if (por_bor_rst) begin
            idle_keep_q <= 1'b0;
        end else begin
            idle_keep_q <= s_d.idle_select;
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end
    // outputs from flops, power-state compares or constants
    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign cpu_cyc_en = s_q.cpu_cyc;
    assign cpu_clk_en = s_q.pwr == CTIC_RUN;
    assign sys_clk_en = s_q.pwr != CTIC_SLEEP;
    assign watchdog_timer_rst_req = s_q.wdt_rst;
    assign watchdog_timer_wake = s_q.wdt_wake;
    // assertions
    idle_keeps_sys_a: assert property (@(posedge clock) disable iff (sys_rst)
        s_q.pwr == CTIC_IDLE |-> sys_clk_en && !cpu_clk_en)
        else $error("idle stopped the system clock");
    sleep_stops_all_a: assert property (@(posedge clock) disable iff (sys_rst)
        s_q.pwr == CTIC_RUN && sleep_exec && !irq_s2 && !s_q.idle_select
        |=> !sys_clk_en && !cpu_clk_en)
        else $error("full sleep not entered");
    recover_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        irq_entry && s_q.recover_on_irq && !return_from_interrupt
        |=> !s_q.cpu_throttle_en)
        else $error("throttle not cleared on irq entry");
    return_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        return_from_interrupt && s_q.throttle_on_return |=> s_q.cpu_throttle_en)
        else $error("throttle not set on return");
    debug_full_a: assert property (@(posedge clock) disable iff (sys_rst)
        dbg_s2 && periph_cyc && s_q.pwr == CTIC_RUN ##1 s_q.pwr == CTIC_RUN
        |=> cpu_cyc_en)
        else $error("debug did not force full speed");
    irq_wake_a: assert property (@(posedge clock) disable iff (sys_rst)
        s_q.pwr == CTIC_IDLE && irq_s2 |=> cpu_clk_en && $stable(s_q.idle_select))
        else $error("irq did not wake idle");
    wdt_wake_a: assert property (@(posedge clock) disable iff (sys_rst)
        s_q.pwr == CTIC_IDLE && wdt_s2 && !irq_s2 && !irq_entry && !return_from_interrupt
        |=> watchdog_timer_wake && !watchdog_timer_rst_req
        && $stable(s_q.cpu_throttle_en))
        else $error("watchdog wake wrong in idle");
    warm_reset_a: assert property (@(posedge clock) disable iff (sys_rst)
        first_q |-> s_q.cpu_throttle_en == 1'b0 && s_q.ratio == 3'h0)
        else $error("fields not cleared by reset");
    idle_cov_c: cover property (@(posedge clock) disable iff (sys_rst)
        s_q.pwr == CTIC_IDLE ##1 s_q.pwr == CTIC_RUN);
    sleep_cov_c: cover property (@(posedge clock) disable iff (sys_rst)
        s_q.pwr == CTIC_SLEEP);
    thr_cov_c: cover property (@(posedge clock) disable iff (sys_rst)
        gif.run && cpu_cyc_en);
endmodule
`default_nettype wire

// *** design/ctic_map.svh ***
// Purpose: offsets, field positions and reset values of the throttle/idle block
// Assumes: one 32-bit AHB-Lite word per register
// Notes: definitions only
`ifndef CTIC_MAP_SVH
`define CTIC_MAP_SVH
`define CTIC_CTRL_OFS 12'h000
`define CTIC_STAT_OFS 12'h004
`define CTIC_IDLE_BIT 7
`define CTIC_THR_BIT 6
`define CTIC_ROI_BIT 5
`define CTIC_TOR_BIT 4
`define CTIC_RATIO_HI 2
`define CTIC_RATIO_LO 0
`define CTIC_CTRL_RST 8'h00
`define CTIC_CTRL_MASK 8'hF7
`define CTIC_RATIO_BASE 3'h1
`endif

// *** design/ctic_pkg.sv ***
// Purpose: types shared by the throttle/idle block
// Assumes: nothing beyond the map header
// Notes: power state names the clock condition of the cpu
package ctic_pkg;
    typedef enum logic [1:0] {CTIC_RUN, CTIC_IDLE, CTIC_SLEEP} ctic_pwr_t;
    typedef logic [7:0] ctic_byte_t;
endpackage

// *** design/ctic_gate_if.sv ***
// Purpose: link between the control top and the throttle gate
// Assumes: single clock
// Notes: ratio and enable in, cpu strobe out
`timescale 1ns/1ps
`default_nettype none
interface ctic_gate_if;
    logic run; // throttle active
    logic [2:0] ratio; // ratio code
    logic cyc; // peripheral instruction cycle
    logic pass; // cpu cycle allowed
    modport ctl (output run, output ratio, output cyc, input pass);
    modport gate (input run, input ratio, input cyc, output pass);
endinterface
`default_nettype wire

// *** design/ctic_gate.sv ***
// Purpose: throttle gate passing one cpu cycle per N peripheral cycles
// Assumes: cyc is a one-clock strobe per peripheral cycle
// Notes: N = 2^(code+1), code 0 counts as 1:2
`timescale 1ns/1ps
`default_nettype none
`include "ctic_map.svh"
module ctic_gate (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // control side
    ctic_gate_if.gate gif
);
    import ctic_pkg::*;
    typedef struct packed {
        logic [7:0] cnt; // peripheral cycles since last pass
        logic pass; // registered pass
    } ctic_gate_st_t;
    ctic_gate_st_t s_q, s_d;
    logic [7:0] last; // count value of last cycle in the period
    // terminal count from the ratio code
    always_comb begin
        // shift a 9-bit two so code 7 reaches 256 without wrapping the shifted value
        last = 8'((9'h002 << gif.ratio) - 9'h001);
    end
    // next state
    always_comb begin
        s_d = s_q;
        s_d.pass = 1'b0;
        if (!gif.run) begin
            s_d.cnt = 8'h00;
            s_d.pass = gif.cyc;
        end else if (gif.cyc) begin
            if (s_q.cnt >= last) begin
                s_d.cnt = 8'h00;
                s_d.pass = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end
    end
    // state register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign gif.pass = s_q.pass;
    // at ratio code 1 with run held, no pass in the two clocks after a pass
    thr_pass_rate_a: assert property (@(posedge clock) disable iff (sys_rst)
        gif.run && gif.ratio == 3'h1 && s_q.pass
        |=> !s_q.pass ##1 (!s_q.pass || !$past(gif.run)))
        else $error("throttle passed two cycles too close");
endmodule
`default_nettype wire

// *** sim/ctic_core_model.sv ***
// Purpose: core-side model, paces peripheral strobes and measures cpu grant spacing
// Assumes: one clock shared with the control block
// Notes: gap counts peripheral strobes between two cpu cycle grants
`timescale 1ns/1ps
`default_nettype none
module ctic_core_model (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // stimulus
    input wire logic slow, // strobe every other clock
    input wire logic sys_clk_en, // peripheral clocks running
    input wire logic cpu_cyc_en, // grant from control block
    // results
    output logic periph_cyc, // peripheral instruction cycle
    output logic [15:0] cpu_gap // strobes between last two grants
);
    logic [15:0] run_cnt; // strobes since last grant
    // no strobes while system clocks are stopped
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            periph_cyc <= 1'b0;
            run_cnt <= 16'h0000;
            cpu_gap <= 16'h0000;
        end else begin
            periph_cyc <= sys_clk_en & (slow ? ~periph_cyc : 1'b1);
            if (cpu_cyc_en) begin
                cpu_gap <= run_cnt + {15'h0000, periph_cyc};
                run_cnt <= 16'h0000;
            end else begin
                run_cnt <= run_cnt + {15'h0000, periph_cyc};
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Purpose: self-checking bench for the throttle/idle control block
// Assumes: zero-wait ahb-lite slave, core model supplies peripheral strobes
// Notes: ratio checks measure grant spacing in peripheral cycles
`timescale 1ns/1ps
`default_nettype none
`include "ctic_map.svh"
module tb;
    // clock, resets and bus
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic por_bor_rst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, hreadyout;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000, hrdata, rd;
    // core events and clock controls
    logic periph_cyc, sleep_exec = 1'b0, irq_entry = 1'b0, return_from_interrupt = 1'b0;
    logic irq_pending = 1'b0, watchdog_timer_timeout = 1'b0, in_circuit_debug = 1'b0;
    logic cpu_cyc_en, cpu_clk_en, sys_clk_en, watchdog_timer_rst_req, watchdog_timer_wake;
    logic slow = 1'b0;
    logic [15:0] cpu_gap;
    int err_total = 0, num_checks = 0, i, c;
    always #2 clock = ~clock;
    ctic_top DUT (.clock, .sys_rst, .por_bor_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp(), .periph_cyc, .sleep_exec,
        .irq_entry, .return_from_interrupt, .irq_pending, .watchdog_timer_timeout,
        .in_circuit_debug, .cpu_cyc_en, .cpu_clk_en, .sys_clk_en, .watchdog_timer_rst_req,
        .watchdog_timer_wake);
    ctic_core_model core (.clock, .sys_rst, .slow, .sys_clk_en, .cpu_cyc_en, .periph_cyc,
        .cpu_gap);
    // compare words and single bits
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h00000000, got}, {31'h00000000, exp});
    endtask
    // one single transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk_word(rd, exp);
    endtask
    // one-clock pulse on sleep, irq entry, return
    task automatic pulse(input logic [2:0] m);
        @(posedge clock);
        {sleep_exec, irq_entry, return_from_interrupt} <= m;
        @(posedge clock);
        {sleep_exec, irq_entry, return_from_interrupt} <= 3'h0;
    endtask
    // settle, then compare last grant spacing
    task automatic gap_chk(input int n, input logic [15:0] exp);
        repeat (n) @(posedge clock);
        chk_word({16'h0000, cpu_gap}, {16'h0000, exp});
    endtask
    // enabled interrupt ends a low-power state
    task automatic wake_irq;
        irq_pending <= 1'b1;
        for (i = 0; i < 10 && cpu_clk_en !== 1'b1; i++) @(posedge clock);
        chk_bit(cpu_clk_en, 1'b1);
        irq_pending <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task automatic final_report;
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        por_bor_rst <= 1'b0;
        rd_chk(`CTIC_CTRL_OFS, 32'h00000000);
        wr(`CTIC_CTRL_OFS, 32'hFFFFFFFF);
        rd_chk(`CTIC_CTRL_OFS, {24'h000000, `CTIC_CTRL_MASK});
        wr(12'h008, 32'hFFFFFFFF);
        rd_chk(12'h008, 32'h00000000);
        // every ratio code, strobes every other clock
        slow <= 1'b1;
        for (c = 0; c < 8; c++) begin
            wr(`CTIC_CTRL_OFS, {24'h000000, 8'h40 | c[7:0]});
            gap_chk(24 << c, 16'h0002 << c);
        end
        slow <= 1'b0;
        wr(`CTIC_CTRL_OFS, 32'h00000007);
        gap_chk(20, 16'h0001);
        // debug forces full speed, stored bit kept
        wr(`CTIC_CTRL_OFS, 32'h00000047);
        in_circuit_debug <= 1'b1;
        gap_chk(600, 16'h0001);
        rd_chk(`CTIC_CTRL_OFS, 32'h00000047);
        in_circuit_debug <= 1'b0;
        gap_chk(1600, 16'h0100);
        // hardware updates of the throttle bit
        wr(`CTIC_CTRL_OFS, 32'h00000060);
        pulse(3'h2);
        rd_chk(`CTIC_CTRL_OFS, 32'h00000020);
        wr(`CTIC_CTRL_OFS, 32'h00000040);
        pulse(3'h2);
        rd_chk(`CTIC_CTRL_OFS, 32'h00000040);
        wr(`CTIC_CTRL_OFS, 32'h00000010);
        pulse(3'h1);
        rd_chk(`CTIC_CTRL_OFS, 32'h00000050);
        wr(`CTIC_CTRL_OFS, 32'h00000000);
        pulse(3'h1);
        rd_chk(`CTIC_CTRL_OFS, 32'h00000000);
        // idle then full sleep, both woken by interrupt
        wr(`CTIC_CTRL_OFS, 32'h00000080);
        pulse(3'h4);
        repeat (3) @(posedge clock);
        chk_bit(cpu_clk_en, 1'b0);
        chk_bit(sys_clk_en, 1'b1);
        rd_chk(`CTIC_STAT_OFS, 32'h00000001);
        wake_irq;
        rd_chk(`CTIC_CTRL_OFS, 32'h00000080);
        wr(`CTIC_CTRL_OFS, 32'h00000000);
        pulse(3'h4);
        repeat (3) @(posedge clock);
        chk_bit(cpu_clk_en, 1'b0);
        chk_bit(sys_clk_en, 1'b0);
        rd_chk(`CTIC_STAT_OFS, 32'h00000002);
        wake_irq;
        // watchdog wakes idle, throttle untouched
        wr(`CTIC_CTRL_OFS, 32'h000000E0);
        pulse(3'h4);
        repeat (3) @(posedge clock);
        watchdog_timer_timeout <= 1'b1;
        for (i = 0; i < 10 && watchdog_timer_wake !== 1'b1; i++) @(posedge clock);
        chk_bit(watchdog_timer_wake, 1'b1);
        watchdog_timer_timeout <= 1'b0;
        repeat (6) @(posedge clock);
        chk_bit(cpu_clk_en, 1'b1);
        rd_chk(`CTIC_CTRL_OFS, 32'h000000E0);
        watchdog_timer_timeout <= 1'b1;
        for (i = 0; i < 10 && watchdog_timer_rst_req !== 1'b1; i++) @(posedge clock);
        chk_bit(watchdog_timer_rst_req, 1'b1);
        watchdog_timer_timeout <= 1'b0;
        // warm reset keeps idle select, power-on clears it
        wr(`CTIC_CTRL_OFS, 32'h00000097);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd_chk(`CTIC_CTRL_OFS, 32'h00000080);
        sys_rst <= 1'b1;
        por_bor_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        por_bor_rst <= 1'b0;
        rd_chk(`CTIC_CTRL_OFS, 32'h00000000);
        final_report;
    end
    // hang guard, roughly five times the expected run
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        final_report;
    end
endmodule
`default_nettype wire
